// ### hw/pmm_top.sv
// Power mode manager: mode sequencing, subsystem enables and Avalon-MM register slave
`timescale 1ns/1ps
module pmm_top #(
    parameter int HOLDOFF_CYCLES = pmm_pkg::HOLDOFF_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic [pmm_pkg::WAKE_NUM-1:0] i_wake_src,
    input wire logic i_irq_any,
    input wire logic i_perf_ctrl_idle,
    input wire logic i_factory_hib_disable_cfg,
    input wire logic i_slow_osc_tick,
    input wire logic i_main_osc_tick,
    output logic [pmm_pkg::SUBSYS-1:0] o_subsys_clk_en,
    output logic [pmm_pkg::SUBSYS-1:0] o_subsys_bias_en,
    output logic o_cpu_en,
    output logic [2:0] o_mode,
    output logic o_dig_reg_buzz,
    output logic o_ana_reg_buzz,
    output logic o_main_reg_on,
    output logic o_hib_reg_on,
    output logic o_wake_direct
);
    import pmm_pkg::*;

    pmm_mode_t mode;
    pmm_mode_t next_mode;
    logic cpu_en;
    logic auto_alt;
    logic avail_lp;
    logic [31:0] holdoff_cnt;
    logic holdoff_done;
    logic rd_ph;
    logic rd_pend;
    logic [7:0] rd_sel;
    logic [7:0] regs_rd;
    logic [SUBSYS-1:0] act_flat;
    logic [SUBSYS-1:0] alt_flat;
    logic [SUBSYS-1:0] avail_flat;
    logic [7:0] act_rdata;
    logic [7:0] alt_rdata;
    logic [7:0] avail_rdata;

    // Address decode
    wire in_act = i_address >= ACT_BASE && i_address < ACT_BASE + 8'(NUM_TPL);
    wire in_alt = i_address >= ALT_BASE && i_address < ALT_BASE + 8'(NUM_TPL);
    wire in_avail = i_address >= AVAIL_BASE && i_address < AVAIL_BASE + 8'(NUM_TPL);
    wire hit_mode = i_address == MODE_OFS;
    wire hit_stat = i_address == STAT_OFS;
    wire hit_cfg = i_address == CFG_OFS;
    wire wr_lane0 = i_write && i_byteenable[0];
    wire [3:0] tpl_idx = in_act ? 4'(i_address - ACT_BASE)
                       : in_alt ? 4'(i_address - ALT_BASE)
                       : 4'(i_address - AVAIL_BASE);
    wire [2:0] wr_code = i_writedata[MODE_LSB +: 3];

    // Template and availability stores
    pmm_tpl_mem #(.DEPTH(NUM_TPL), .RST_VAL(ACT_RST)) u_act (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(wr_lane0 && in_act),
        .i_addr(tpl_idx),
        .i_wdata(i_writedata[7:0]),
        .o_rdata(act_rdata),
        .o_flat(act_flat)
    );
    pmm_tpl_mem #(.DEPTH(NUM_TPL), .RST_VAL(ALT_RST)) u_alt (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(wr_lane0 && in_alt),
        .i_addr(tpl_idx),
        .i_wdata(i_writedata[7:0]),
        .o_rdata(alt_rdata),
        .o_flat(alt_flat)
    );
    pmm_tpl_mem #(.DEPTH(NUM_TPL), .RST_VAL(AVAIL_RST)) u_avail (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(wr_lane0 && in_avail),
        .i_addr(tpl_idx),
        .i_wdata(i_writedata[7:0]),
        .o_rdata(avail_rdata),
        .o_flat(avail_flat)
    );

    // Wakeup qualification per mode: sleep and hibernate take only their own sources
    wire wake_any = |i_wake_src;
    wire wake_sleep = |(i_wake_src & SLEEP_WAKE_MASK);
    wire wake_hib = |(i_wake_src & HIB_WAKE_MASK);
    wire pending = wake_any || i_irq_any;
    wire holdoff = !holdoff_done;

    // Requested target from a firmware mode write; hibernate may be demoted
    wire mode_wr = wr_lane0 && hit_mode;
    wire req_hib = wr_code == CODE_HIB;
    wire req_hib_ok = req_hib && !i_factory_hib_disable_cfg;
    wire req_sleep = wr_code == CODE_SLEEP || (req_hib && i_factory_hib_disable_cfg);

    // Mode sequencer
    always_comb begin
        next_mode = mode;
        case (mode)
            PMM_ACTIVE: begin
                // Any pending wakeup pins the device in active
                if (mode_wr && !pending) begin
                    if (wr_code == CODE_ALT) begin
                        next_mode = PMM_ALT;
                    end else if (req_sleep && !holdoff) begin
                        next_mode = PMM_SLEEP;
                    end else if (req_hib_ok && !holdoff) begin
                        next_mode = PMM_HIB;
                    end
                end else if (auto_alt && i_slow_osc_tick && !pending) begin
                    next_mode = PMM_ALT;
                end
            end
            PMM_ALT: begin
                if (wake_any || i_irq_any) begin
                    next_mode = PMM_ACTIVE;
                end else if (mode_wr && wr_code == CODE_ACT) begin
                    next_mode = PMM_ACTIVE;
                end else if (auto_alt && i_main_osc_tick) begin
                    next_mode = PMM_ACTIVE;
                end
            end
            PMM_SLEEP: begin
                if (wake_sleep) begin
                    next_mode = PMM_ACTIVE;
                end
            end
            PMM_HIB: begin
                if (wake_hib) begin
                    next_mode = PMM_ACTIVE;
                end
            end
            default: next_mode = PMM_ACTIVE;
        endcase
    end

    wire enter_active = next_mode == PMM_ACTIVE && mode != PMM_ACTIVE;
    wire leave_lowpow = mode == PMM_SLEEP || mode == PMM_HIB;

    // Mode register; reset lands in active
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= PMM_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    // CPU enable: firmware may clear its own bit; any return to active sets it again
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cpu_en <= 1'b1;
        end else if (enter_active) begin
            cpu_en <= 1'b1;
        end else if (wr_lane0 && in_act && tpl_idx == 4'h0) begin
            cpu_en <= i_writedata[CPU_BIT];
        end
    end

    // Availability mask applies only after returning from sleep or hibernate
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            avail_lp <= 1'b0;
        end else if (enter_active) begin
            avail_lp <= leave_lowpow;
        end else if (mode_wr && wr_code == CODE_ACT) begin
            avail_lp <= 1'b0;
        end
    end

    // Power-on hold-off counter; sleep and hibernate entry both wait for it
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            holdoff_cnt <= 32'h0;
            holdoff_done <= 1'b0;
        end else if (!holdoff_done) begin
            holdoff_cnt <= holdoff_cnt + 32'h1;
            holdoff_done <= holdoff_cnt >= 32'(HOLDOFF_CYCLES - 1);
        end
    end

    // Configuration register: auto-alternating mode enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            auto_alt <= 1'b0;
        end else if (wr_lane0 && hit_cfg) begin
            auto_alt <= i_writedata[AUTO_BIT];
        end
    end

    // Subsystem enables: template by mode, forced off in low-power modes
    logic [SUBSYS-1:0] tpl_sel;
    always_comb begin
        case (mode)
            PMM_ACTIVE: tpl_sel = avail_lp ? (act_flat & avail_flat) : act_flat;
            PMM_ALT: tpl_sel = alt_flat;
            default: tpl_sel = '0;
        endcase
    end

    // Outputs: both clock gate and bias follow the same enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_subsys_clk_en <= {SUBSYS{1'b1}};
            o_subsys_bias_en <= {SUBSYS{1'b1}};
            o_cpu_en <= 1'b1;
        end else begin
            o_subsys_clk_en <= tpl_sel;
            o_subsys_bias_en <= tpl_sel;
            o_cpu_en <= (mode == PMM_ACTIVE) ? cpu_en
                      : (mode == PMM_ALT) ? alt_flat[CPU_BIT] : 1'b0;
        end
    end

    // Regulator controls and mode code report
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mode <= CODE_ACT;
            o_dig_reg_buzz <= 1'b0;
            o_ana_reg_buzz <= 1'b0;
            o_main_reg_on <= 1'b1;
            o_hib_reg_on <= 1'b1;
            o_wake_direct <= 1'b0;
        end else begin
            o_mode <= mode == PMM_ALT ? CODE_ALT : mode == PMM_SLEEP ? CODE_SLEEP
                    : mode == PMM_HIB ? CODE_HIB : CODE_ACT;
            o_dig_reg_buzz <= mode == PMM_SLEEP;
            o_ana_reg_buzz <= mode == PMM_SLEEP;
            o_main_reg_on <= mode == PMM_ACTIVE || mode == PMM_ALT;
            o_hib_reg_on <= 1'b1;
            o_wake_direct <= leave_lowpow;
        end
    end

    // Local register readback mux
    assign regs_rd = hit_mode ? {4'h0, auto_alt, 3'(o_mode)}
                   : hit_stat ? {2'h0, holdoff_done, i_perf_ctrl_idle, avail_lp, cpu_en, 2'(mode)}
                   : hit_cfg ? {4'h0, auto_alt, 3'h0}
                   : 8'h00;

    // Avalon slave: writes complete at once; reads wait two cycles so that a
    // template word can first pass through its memory's read register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_ph <= 1'b0;
            rd_pend <= 1'b0;
            rd_sel <= 8'h00;
        end else begin
            rd_ph <= i_read && !rd_ph && !rd_pend;
            rd_pend <= rd_ph;
            rd_sel <= i_address;
        end
    end

    assign o_waitrequest = i_read && !rd_pend;

    // Template word selected by the address captured one cycle earlier
    wire [7:0] mem_rd = (rd_sel >= ALT_BASE && rd_sel < ALT_BASE + 8'(NUM_TPL)) ? alt_rdata
                      : (rd_sel >= AVAIL_BASE && rd_sel < AVAIL_BASE + 8'(NUM_TPL)) ? avail_rdata
                      : (rd_sel < ACT_BASE + 8'(NUM_TPL)) ? act_rdata : 8'h00;

    // Read data register loads once the memory word is registered; stands until next read
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_readdata <= 32'h0;
        end else if (rd_ph) begin
            o_readdata <= {24'h0, regs_rd | mem_rd};
        end
    end
endmodule : pmm_top

// ### hw/pmm_pkg.sv
// Package with register map, mode codes and timing constants for the power mode manager
package pmm_pkg;
    localparam int NUM_TPL = 14;
    localparam int SUBSYS = NUM_TPL * 8;
    localparam int CPU_BIT = 0;
    // Word offsets (byte address = 4 * index)
    localparam logic [7:0] ACT_BASE = 8'h00;
    localparam logic [7:0] ALT_BASE = 8'h10;
    localparam logic [7:0] AVAIL_BASE = 8'h20;
    localparam logic [7:0] MODE_OFS = 8'h30;
    localparam logic [7:0] STAT_OFS = 8'h31;
    localparam logic [7:0] CFG_OFS = 8'h32;
    // Mode-select codes
    localparam logic [2:0] CODE_ACT = 3'h0;
    localparam logic [2:0] CODE_ALT = 3'h1;
    localparam logic [2:0] CODE_SLEEP = 3'h3;
    localparam logic [2:0] CODE_HIB = 3'h4;
    // Field positions
    localparam int MODE_LSB = 0;
    localparam int AUTO_BIT = 3;
    localparam int STAT_IDLE_BIT = 4;
    localparam int WAKE_NUM = 6;
    // Wakeup source bits
    localparam int WK_CMP = 0;
    localparam int WK_PIN = 1;
    localparam int WK_I2C = 2;
    localparam int WK_RTC = 3;
    localparam int WK_CTW = 4;
    localparam int WK_OTHER = 5;
    localparam logic [5:0] SLEEP_WAKE_MASK = 6'h1f;
    localparam logic [5:0] HIB_WAKE_MASK = 6'h03;
    // Reset values
    localparam logic [7:0] ACT_RST = 8'hff;
    localparam logic [7:0] ALT_RST = 8'h00;
    localparam logic [7:0] AVAIL_RST = 8'hff;
    // Power-on hold-off time for low-power entry
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int HOLDOFF_US = 1000;
    localparam int HOLDOFF_CYC = (SYS_CLK_HZ / 1_000_000) * HOLDOFF_US;
    typedef enum logic [2:0] {
        PMM_ACTIVE,
        PMM_ALT,
        PMM_SLEEP,
        PMM_HIB
    } pmm_mode_t;
endpackage : pmm_pkg

// ### hw/pmm_tpl_mem.sv
// Template memory: 8-bit words, registered read port, parallel flat view for enables
`timescale 1ns/1ps
module pmm_tpl_mem #(
    parameter int DEPTH = 14,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_we,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic [DEPTH*8-1:0] o_flat
);
    // One flop word per entry; every bit drives a subsystem so all are visible at once
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            logic [7:0] word;
            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    word <= RST_VAL;
                end else if (i_we && i_addr == 4'(g)) begin
                    word <= i_wdata;
                end
            end
            assign o_flat[g*8 +: 8] = word;
        end
    endgenerate

    // Registered read data, taken from the flat view so each word keeps a single writer
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= (i_addr < 4'(DEPTH)) ? o_flat[i_addr*8 +: 8] : 8'h00;
        end
    end
endmodule : pmm_tpl_mem

// ### testbench/pmm_assertions.sv
// Checker of mode sequencing and power outputs of the power mode manager
`timescale 1ns/1ps
module pmm_checker
    import pmm_pkg::*;
#(
    parameter int HOLDOFF_CYCLES = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_address,
    input wire logic i_write,
    input wire logic [pmm_pkg::WAKE_NUM-1:0] i_wake_src,
    input wire logic i_irq_any,
    input wire logic i_slow_osc_tick,
    input wire logic [pmm_pkg::SUBSYS-1:0] o_subsys_clk_en,
    input wire logic [pmm_pkg::SUBSYS-1:0] o_subsys_bias_en,
    input wire logic o_cpu_en,
    input wire logic [2:0] o_mode,
    input wire logic o_dig_reg_buzz,
    input wire logic o_ana_reg_buzz,
    input wire logic o_main_reg_on,
    input wire logic o_hib_reg_on,
    input wire logic o_wake_direct
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    int unsigned up_cnt;
    // Cycles since reset release, saturating so it never wraps
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            up_cnt <= 0;
        end else if (up_cnt < HOLDOFF_CYCLES + 4) begin
            up_cnt <= up_cnt + 1;
        end
    end
    // Two cycles in a mode, so registered outputs have caught up
    sequence s_sleep_held;
        o_mode == CODE_SLEEP ##1 o_mode == CODE_SLEEP;
    endsequence
    sequence s_hib_held;
        o_mode == CODE_HIB ##1 o_mode == CODE_HIB;
    endsequence
    sleep_all_off_a: assert property (s_sleep_held |->
        o_subsys_clk_en == '0 && o_subsys_bias_en == '0)
        else $error("subsystem left on in sleep");
    sleep_buzz_a: assert property (s_sleep_held |->
        o_dig_reg_buzz && o_ana_reg_buzz && o_wake_direct)
        else $error("sleep regulators or wake path wrong");
    hib_regs_a: assert property (s_hib_held |-> o_hib_reg_on && !o_main_reg_on &&
        !o_dig_reg_buzz && !o_ana_reg_buzz && o_subsys_clk_en == '0)
        else $error("hibernate supply state wrong");
    // A wakeup sampled last cycle may already have moved the state ahead of o_mode
    hib_ignore_a: assert property (o_mode == CODE_HIB && !i_irq_any
        && (i_wake_src & HIB_WAKE_MASK) == '0 && ($past(i_wake_src) & HIB_WAKE_MASK) == '0
        |=> o_mode == CODE_HIB)
        else $error("hibernate left without a valid wakeup");
    wake_to_act_a: assert property (o_mode == CODE_SLEEP
        && |(i_wake_src & SLEEP_WAKE_MASK) |-> ##[1:3] (o_mode == CODE_ACT && o_cpu_en))
        else $error("sleep wakeup did not land in active");
    alt_irq_exit_a: assert property (o_mode == CODE_ALT && i_irq_any
        |-> ##[1:3] (o_mode == CODE_ACT && o_cpu_en))
        else $error("interrupt did not end alternate active");
    // State register then o_mode each add one cycle after the request
    alt_entry_a: assert property (o_mode == CODE_ALT && $past(o_mode) != CODE_ALT
        |-> $past(i_write && i_address == MODE_OFS, 2) || $past(i_slow_osc_tick, 2))
        else $error("alternate active entered without request");
    pend_refuse_a: assert property (o_mode == CODE_ACT && i_write
        && i_address == MODE_OFS && (|i_wake_src || i_irq_any) |=> o_mode == CODE_ACT [*3])
        else $error("mode left active while wakeup pending");
    holdoff_a: assert property (up_cnt + 2 < HOLDOFF_CYCLES
        |-> o_mode != CODE_SLEEP && o_mode != CODE_HIB)
        else $error("low power mode entered during hold-off");
    boot_act_a: assert property ($past(i_rstn) == 1'b0
        |-> o_mode == CODE_ACT && o_cpu_en)
        else $error("mode after reset is not active");
endmodule : pmm_checker

// ### testbench/pmm_wake_model.sv
// Behavioural wakeup sources and firmware status facing the power mode manager
`timescale 1ns/1ps
module pmm_wake_model
    import pmm_pkg::*;
#(
    parameter int HOLD = 4
) (
    input wire logic i_sys_clk,
    input wire logic [pmm_pkg::WAKE_NUM-1:0] i_fire,
    input wire logic i_irq,
    output logic [pmm_pkg::WAKE_NUM-1:0] o_wake_src = '0,
    output logic o_irq_any = 1'b0,
    output logic o_perf_ctrl_idle
);
    int left = 0;
    // Sources are levels held for HOLD cycles, no edge detect in the path
    always @(posedge i_sys_clk) begin
        if (|i_fire || i_irq) begin
            o_wake_src <= i_fire;
            o_irq_any <= i_irq;
            left <= HOLD;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            o_wake_src <= '0;
            o_irq_any <= 1'b0;
            left <= 0;
        end
    end
    // Controller reported idle; the manager only shows it in its status word, mode writes do not wait for it
    assign o_perf_ctrl_idle = 1'b1;
endmodule : pmm_wake_model

// ### testbench/tb_top.sv
// Self-checking bench for the power mode manager
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import pmm_pkg::*;
    localparam int HOLD = 20;
    logic clk = 0, rstn = 0, rd = 0, wr = 0, hib_dis = 0, slow = 0, fast = 0, irq = 0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, rdv;
    logic [5:0] fire = '0, wake;
    logic wreq, irq_any, idle, cpu, dbz, abz, mreg, hreg, wdir;
    logic [2:0] mode;
    logic [SUBSYS-1:0] clk_en, bias_en;
    int failures = 0, n_tests = 0, cyc = 0;
    // 20 MHz system clock
    always #25 clk = ~clk;
    pmm_top #(.HOLDOFF_CYCLES(HOLD)) pmm_top_i (
        .i_sys_clk(clk), .i_rstn(rstn), .i_address(addr), .i_read(rd), .i_write(wr),
        .i_writedata(wdata), .i_byteenable(4'h1), .o_readdata(rdata), .o_waitrequest(wreq),
        .i_wake_src(wake), .i_irq_any(irq_any), .i_perf_ctrl_idle(idle),
        .i_factory_hib_disable_cfg(hib_dis), .i_slow_osc_tick(slow), .i_main_osc_tick(fast),
        .o_subsys_clk_en(clk_en), .o_subsys_bias_en(bias_en), .o_cpu_en(cpu), .o_mode(mode),
        .o_dig_reg_buzz(dbz), .o_ana_reg_buzz(abz), .o_main_reg_on(mreg), .o_hib_reg_on(hreg),
        .o_wake_direct(wdir));
    pmm_wake_model pmm_wake_model_i (.i_sys_clk(clk), .i_fire(fire), .i_irq(irq),
        .o_wake_src(wake), .o_irq_any(irq_any), .o_perf_ctrl_idle(idle));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    // Avalon-MM cycles: request held until waitrequest is sampled low
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= 1'b1;
        @(posedge clk);
        while (wreq) @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        while (wreq) @(posedge clk);
        d = rdata;
        rd <= 1'b0;
    endtask : rd_reg
    task automatic set_mode(input logic [2:0] c);
        wr_reg(MODE_OFS, {5'h0, c});
    endtask : set_mode
    task automatic kick(input logic [5:0] s, input logic i);
        @(posedge clk);
        fire <= s;
        irq <= i;
        @(posedge clk);
        fire <= '0;
        irq <= 1'b0;
    endtask : kick
    // Bounded wait for a mode, plus one cycle for registered enables
    task automatic want_mode(input logic [2:0] m, input string nm);
        int k;
        k = 0;
        while (mode !== m && k < 10) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        `CHK(nm, m, mode)
    endtask : want_mode
    task automatic hold_chk(input logic [2:0] m, input string nm);
        repeat (6) @(posedge clk);
        `CHK(nm, m, mode)
    endtask : hold_chk
    task automatic t_boot();
        `CHK("cpu", 1'b1, cpu)
        `CHK("clk_en", {SUBSYS{1'b1}}, clk_en)
        set_mode(CODE_SLEEP);
        hold_chk(CODE_ACT, "early sleep");
        repeat (HOLD) @(posedge clk);
        $display("boot test done");
    endtask : t_boot
    task automatic t_sleep();
        wr_reg(AVAIL_BASE, 8'hfb);
        set_mode(CODE_SLEEP);
        want_mode(CODE_SLEEP, "sleep");
        `CHK("bias", {SUBSYS{1'b0}}, bias_en)
        `CHK("buzz", 2'b11, {dbz, abz})
        `CHK("direct", 1'b1, wdir)
        kick(6'h08, 1'b0);
        want_mode(CODE_ACT, "sleep wake");
        `CHK("cpu", 1'b1, cpu)
        `CHK("avail", 8'hfb, clk_en[7:0])
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_hib();
        set_mode(CODE_HIB);
        want_mode(CODE_HIB, "hib");
        `CHK("regs", 2'b10, {hreg, mreg})
        kick(6'h04, 1'b0);
        hold_chk(CODE_HIB, "hib i2c");
        kick(6'h02, 1'b0);
        want_mode(CODE_ACT, "hib wake");
        hib_dis <= 1'b1;
        set_mode(CODE_HIB);
        want_mode(CODE_SLEEP, "hib barred");
        kick(6'h01, 1'b0);
        want_mode(CODE_ACT, "cmp wake");
        hib_dis <= 1'b0;
        $display("hibernate test done");
    endtask : t_hib
    task automatic t_alt();
        wr_reg(ACT_BASE, 8'hfe);
        repeat (2) @(posedge clk);
        `CHK("cpu off", 1'b0, cpu)
        wr_reg(ALT_BASE, 8'h5a);
        set_mode(CODE_ALT);
        want_mode(CODE_ALT, "alt");
        `CHK("alt tpl", 8'h5a, clk_en[7:0])
        rd_reg(MODE_OFS, rdv);
        `CHK("mode rd", CODE_ALT, rdv[2:0])
        rd_reg(ALT_BASE, rdv);
        `CHK("alt word", 32'h5a, rdv)
        rd_reg(STAT_OFS, rdv);
        `CHK("idle bit", 1'b1, rdv[STAT_IDLE_BIT])
        rd_reg(ACT_BASE + 8'(NUM_TPL), rdv);
        `CHK("past template", 32'h0, rdv)
        kick(6'h00, 1'b1);
        want_mode(CODE_ACT, "alt irq");
        `CHK("cpu on", 1'b1, cpu)
        set_mode(CODE_ALT);
        want_mode(CODE_ALT, "alt again");
        set_mode(CODE_ACT);
        want_mode(CODE_ACT, "code zero");
        wr_reg(ACT_BASE, 8'hff);
        $display("alternate test done");
    endtask : t_alt
    task automatic t_refuse();
        kick(6'h20, 1'b0);
        set_mode(CODE_SLEEP);
        hold_chk(CODE_ACT, "pending");
        set_mode(3'h2);
        hold_chk(CODE_ACT, "unused code");
        $display("refusal test done");
    endtask : t_refuse
    task automatic t_auto();
        wr_reg(CFG_OFS, 8'h08);
        wr_reg(MODE_OFS, 8'h08);
        slow <= 1'b1;
        @(posedge clk);
        slow <= 1'b0;
        want_mode(CODE_ALT, "auto alt");
        fast <= 1'b1;
        @(posedge clk);
        fast <= 1'b0;
        want_mode(CODE_ACT, "auto act");
        wr_reg(CFG_OFS, 8'h00);
        wr_reg(MODE_OFS, 8'h00);
        $display("auto test done");
    endtask : t_auto
    // Reset in mid-run must land in active from alternate active
    task automatic t_reset();
        set_mode(CODE_ALT);
        want_mode(CODE_ALT, "alt before reset");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("reset mode", CODE_ACT, mode)
        rstn <= 1'b1;
        @(posedge clk);
        `CHK("reset cpu", 1'b1, cpu)
        $display("reset test done");
    endtask : t_reset
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK("boot mode", CODE_ACT, mode)
        t_boot();
        t_sleep();
        t_hib();
        t_alt();
        t_refuse();
        t_auto();
        t_reset();
        wrap_up();
    end
endmodule : tb_top
bind pmm_top pmm_checker #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) pmm_checker_i (.i_sys_clk, .i_rstn,
    .i_address, .i_write, .i_wake_src, .i_irq_any, .i_slow_osc_tick, .o_subsys_clk_en,
    .o_subsys_bias_en, .o_cpu_en, .o_mode, .o_dig_reg_buzz, .o_ana_reg_buzz, .o_main_reg_on,
    .o_hib_reg_on, .o_wake_direct);
